/* File: hw/idl_consts.svh */
// Constants for the interrupt dispatch logic: bit positions, resets, counts
`ifndef IDL_CONSTS_SVH
`define IDL_CONSTS_SVH

// ************************************************************
// Sources, indexed in priority order (lowest index wins)
// ************************************************************
`define IDL_NSRC 3
`define IDL_SRC_INT0 0
`define IDL_SRC_PCHG 1
`define IDL_SRC_TOV 2

// ************************************************************
// Field positions
// ************************************************************
`define IDL_INT0_EN_BIT 6
`define IDL_PCHG_EN_BIT 5
`define IDL_TOV_EN_BIT 1
`define IDL_INT0_FLAG_BIT 6
`define IDL_PCHG_FLAG_BIT 5
`define IDL_TOV_FLAG_BIT 1
`define IDL_GIE_BIT 7

// ************************************************************
// Reset values
// ************************************************************
`define IDL_MASK_RST 1'b0
`define IDL_FLAG_RST 1'b0
`define IDL_GIE_RST 1'b0
`define IDL_PC_RST 9'h000

// ************************************************************
// Timing counts in core clock cycles, and vectors
// ************************************************************
`define IDL_RESP_CYC 4'h4
`define IDL_WAKE_CYC 4'h4
`define IDL_JUMP_CYC 4'h2
`define IDL_RET_CYC 4'h4
`define IDL_VEC_FIRST 9'h001

`endif

/* File: hw/idl_pkg.sv */
// Types shared by the interrupt dispatch logic
package idl_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RESP,
        ST_JUMP,
        ST_RET,
        ST_HOLD
    } idl_state_t;

    // Order matches the two-bit sense control field
    typedef enum logic [1:0] {
        SENSE_LOW,
        SENSE_ANY,
        SENSE_FALL,
        SENSE_RISE
    } idl_sense_t;

endpackage

/* File: hw/idl_flag_bank.sv */
// Latched interrupt flags, one cell per source
`timescale 1ns/1ps
`include "idl_consts.svh"

module idl_flag_bank #(
    parameter int NSRC = `IDL_NSRC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [NSRC-1:0] set_evt,
    input wire logic [NSRC-1:0] sw_clr,
    input wire logic [NSRC-1:0] hw_clr,
    input wire logic [NSRC-1:0] force_clr,
    output logic [NSRC-1:0] flag_q
);

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    for (genvar i = 0; i < NSRC; i++) begin : g_flag
        // A new event beats a software or hardware clear in the same cycle; a forced clear beats both
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                flag_q[i] <= `IDL_FLAG_RST;
            end else if (ce) begin
                if (force_clr[i]) begin
                    flag_q[i] <= 1'b0;
                end else if (set_evt[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (sw_clr[i] || hw_clr[i]) begin
                    flag_q[i] <= 1'b0;
                end
            end
        end

        flag_set_a: assert property (
            ce && set_evt[i] && !force_clr[i] |=> flag_q[i])
            else $error("flag not latched on event");
        flag_wclr_a: assert property (
            ce && sw_clr[i] && !set_evt[i] |=> !flag_q[i])
            else $error("flag not cleared by write of one");
        flag_hold_a: assert property (
            flag_q[i] && !(ce && (sw_clr[i] || hw_clr[i] || force_clr[i]))
            |=> flag_q[i])
            else $error("flag dropped without a clear");
    end

endmodule

/* File: hw/idl_dispatch.sv */
// Interrupt dispatch: masks, flags, global enable, entry and return timing
// Notes on behaviour
// - accepting an interrupt clears global enable
// - software may set global enable to nest
// - return instruction sets global enable
// - vectoring clears the serviced source's flag
// - writing one clears flag, zero keeps
// - flag latches even while source disabled
// - requests wait for global enable, priority order
// - level external interrupt has no flag
// - status register never saved or restored here
// - response takes four cycles before vector
// - nine-bit program counter pushed during response
// - vector jump takes two further cycles
// - multi-cycle instruction finishes before response
// - waking from sleep adds four cycles
// - two eight-bit mask registers
// - return takes four cycles, one instruction follows
`timescale 1ns/1ps
`include "idl_consts.svh"

module idl_dispatch (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic int0_pin,
    input wire logic [1:0] int0_sense,
    input wire logic pin_change_evt,
    input wire logic timer_ovf_evt,
    input wire logic [7:0] io_wdata,
    input wire logic ext_mask_wr,
    input wire logic timer_mask_wr,
    input wire logic ext_flag_wr,
    input wire logic timer_flag_wr,
    input wire logic gie_wr,
    input wire logic instr_done,
    input wire logic sleeping,
    input wire logic return_from_handler_instruction_exec,
    input wire logic [8:0] pc_now,
    output logic gie_q,
    output logic [7:0] external_irq_mask_reg,
    output logic [7:0] timer_irq_mask_reg,
    output logic [7:0] ext_flag_reg,
    output logic [7:0] timer_flag_reg,
    output logic irq_accept,
    output logic core_hold,
    output logic jump_busy,
    output logic push_valid_q,
    output logic [8:0] push_pc_q,
    output logic pop_valid_q,
    output logic vector_load_q,
    output logic [8:0] vector_addr_q
);

    localparam int NSRC = `IDL_NSRC;

    idl_pkg::idl_state_t state_q;
    idl_pkg::idl_sense_t sense;
    logic [3:0] cnt_q;
    logic int0_prev_q;
    logic int0_en_q;
    logic pchg_en_q;
    logic tov_en_q;
    logic level_mode;
    logic int0_edge;
    logic [NSRC-1:0] set_evt;
    logic [NSRC-1:0] sw_clr;
    logic [NSRC-1:0] hw_clr;
    logic [NSRC-1:0] force_clr;
    logic [NSRC-1:0] flag_q;
    logic [NSRC-1:0] req;
    logic [1:0] pick_idx;
    logic [1:0] srv_idx_q;
    logic woke_q;
    logic can_take;
    logic ret_start;
    logic resp_end;
    logic ret_end;

    // ************************************************************
    // External pin sensing
    // ************************************************************
    assign sense = idl_pkg::idl_sense_t'(int0_sense);
    assign level_mode = (sense == idl_pkg::SENSE_LOW);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int0_prev_q <= 1'b1;
        end else if (ce) begin
            int0_prev_q <= int0_pin;
        end
    end

    always_comb begin
        case (sense)
            idl_pkg::SENSE_ANY: int0_edge = int0_pin ^ int0_prev_q;
            idl_pkg::SENSE_FALL: int0_edge = int0_prev_q & ~int0_pin;
            idl_pkg::SENSE_RISE: int0_edge = ~int0_prev_q & int0_pin;
            default: int0_edge = 1'b0;
        endcase
    end

    // ************************************************************
    // Mask registers
    // ************************************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            int0_en_q <= `IDL_MASK_RST;
            pchg_en_q <= `IDL_MASK_RST;
            tov_en_q <= `IDL_MASK_RST;
        end else if (ce) begin
            if (ext_mask_wr) begin
                int0_en_q <= io_wdata[`IDL_INT0_EN_BIT];
                pchg_en_q <= io_wdata[`IDL_PCHG_EN_BIT];
            end
            if (timer_mask_wr) begin
                tov_en_q <= io_wdata[`IDL_TOV_EN_BIT];
            end
        end
    end

    // Reserved positions are never stored, so they read as zero
    always_comb begin
        external_irq_mask_reg = 8'h00;
        external_irq_mask_reg[`IDL_INT0_EN_BIT] = int0_en_q;
        external_irq_mask_reg[`IDL_PCHG_EN_BIT] = pchg_en_q;
        timer_irq_mask_reg = 8'h00;
        timer_irq_mask_reg[`IDL_TOV_EN_BIT] = tov_en_q;
        ext_flag_reg = 8'h00;
        ext_flag_reg[`IDL_INT0_FLAG_BIT] = flag_q[`IDL_SRC_INT0];
        ext_flag_reg[`IDL_PCHG_FLAG_BIT] = flag_q[`IDL_SRC_PCHG];
        timer_flag_reg = 8'h00;
        timer_flag_reg[`IDL_TOV_FLAG_BIT] = flag_q[`IDL_SRC_TOV];
    end

    // ************************************************************
    // Flags and requests
    // ************************************************************
    // Level mode keeps the external flag forced low: the request follows
    // the pin directly and nothing is remembered
    assign set_evt[`IDL_SRC_INT0] = int0_edge & ~level_mode;
    assign set_evt[`IDL_SRC_PCHG] = pin_change_evt;
    assign set_evt[`IDL_SRC_TOV] = timer_ovf_evt;
    assign sw_clr[`IDL_SRC_INT0] = ext_flag_wr & io_wdata[`IDL_INT0_FLAG_BIT];
    assign sw_clr[`IDL_SRC_PCHG] = ext_flag_wr & io_wdata[`IDL_PCHG_FLAG_BIT];
    assign sw_clr[`IDL_SRC_TOV] = timer_flag_wr & io_wdata[`IDL_TOV_FLAG_BIT];
    assign force_clr = {{(NSRC-1){1'b0}}, level_mode};

    idl_flag_bank #(
        .NSRC(NSRC)
    ) u_flags (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .set_evt(set_evt),
        .sw_clr(sw_clr),
        .hw_clr(hw_clr),
        .force_clr(force_clr),
        .flag_q(flag_q)
    );

    assign req[`IDL_SRC_INT0] = int0_en_q &
        (level_mode ? ~int0_pin : flag_q[`IDL_SRC_INT0]);
    assign req[`IDL_SRC_PCHG] = pchg_en_q & flag_q[`IDL_SRC_PCHG];
    assign req[`IDL_SRC_TOV] = tov_en_q & flag_q[`IDL_SRC_TOV];

    always_comb begin
        pick_idx = 2'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                pick_idx = 2'(i);
            end
        end
    end

    // ************************************************************
    // Entry and return sequencing
    // ************************************************************
    // Acceptance only at an instruction boundary, or from sleep; after a
    // return the first boundary is the one that ends the extra instruction
    assign can_take = gie_q && (|req) &&
        (((state_q == idl_pkg::ST_IDLE) && (instr_done || sleeping)) ||
         ((state_q == idl_pkg::ST_HOLD) && instr_done));
    assign irq_accept = ce && can_take;
    assign ret_start = ce && return_from_handler_instruction_exec && !can_take &&
        ((state_q == idl_pkg::ST_IDLE) || (state_q == idl_pkg::ST_HOLD));
    assign resp_end = ce && (state_q == idl_pkg::ST_RESP) && (cnt_q == 4'h0);
    assign ret_end = ce && (state_q == idl_pkg::ST_RET) && (cnt_q == 4'h0);
    assign hw_clr = resp_end ? NSRC'(1) << srv_idx_q : '0;
    assign core_hold = (state_q == idl_pkg::ST_RESP) ||
        (state_q == idl_pkg::ST_JUMP) || (state_q == idl_pkg::ST_RET);
    assign jump_busy = (state_q == idl_pkg::ST_JUMP);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= idl_pkg::ST_IDLE;
            cnt_q <= 4'h0;
        end else if (ce) begin
            case (state_q)
                idl_pkg::ST_IDLE, idl_pkg::ST_HOLD: begin
                    if (irq_accept) begin
                        state_q <= idl_pkg::ST_RESP;
                        cnt_q <= sleeping ?
                            `IDL_RESP_CYC + `IDL_WAKE_CYC - 4'h1 :
                            `IDL_RESP_CYC - 4'h1;
                    end else if (ret_start) begin
                        state_q <= idl_pkg::ST_RET;
                        cnt_q <= `IDL_RET_CYC - 4'h1;
                    end else if (instr_done) begin
                        state_q <= idl_pkg::ST_IDLE;
                    end
                end
                idl_pkg::ST_RESP, idl_pkg::ST_JUMP, idl_pkg::ST_RET: begin
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else if (state_q == idl_pkg::ST_RESP) begin
                        state_q <= idl_pkg::ST_JUMP;
                        cnt_q <= `IDL_JUMP_CYC - 4'h1;
                    end else if (state_q == idl_pkg::ST_JUMP) begin
                        state_q <= idl_pkg::ST_IDLE;
                    end else begin
                        state_q <= idl_pkg::ST_HOLD;
                    end
                end
                default: begin
                    state_q <= idl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Entry wins over a software write in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gie_q <= `IDL_GIE_RST;
        end else if (ce) begin
            if (irq_accept) begin
                gie_q <= 1'b0;
            end else if (ret_end) begin
                gie_q <= 1'b1;
            end else if (gie_wr) begin
                gie_q <= io_wdata[`IDL_GIE_BIT];
            end
        end
    end

    // Only the program counter is stacked; status stays with the handler
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            srv_idx_q <= 2'h0;
            woke_q <= 1'b0;
            push_valid_q <= 1'b0;
            push_pc_q <= `IDL_PC_RST;
            pop_valid_q <= 1'b0;
            vector_load_q <= 1'b0;
            vector_addr_q <= `IDL_PC_RST;
        end else if (ce) begin
            push_valid_q <= irq_accept;
            pop_valid_q <= ret_start;
            vector_load_q <= resp_end;
            if (irq_accept) begin
                srv_idx_q <= pick_idx;
                woke_q <= sleeping;
                push_pc_q <= pc_now;
            end
            if (resp_end) begin
                vector_addr_q <= `IDL_VEC_FIRST + {7'h00, srv_idx_q};
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [3:0] age_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            age_q <= 4'h0;
        end else if (ce) begin
            if (irq_accept || ret_start) begin
                age_q <= 4'h0;
            end else if (core_hold && age_q != 4'hf) begin
                age_q <= age_q + 4'h1;
            end
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    gie_entry_clr_a: assert property (irq_accept |=> !gie_q)
        else $error("global enable not cleared on entry");
    gie_sw_set_a: assert property (
        ce && gie_wr && io_wdata[`IDL_GIE_BIT] && !irq_accept |=> gie_q)
        else $error("software could not set global enable");
    gie_ret_set_a: assert property (ret_end |=> gie_q)
        else $error("return did not set global enable");
    flag_vec_clr_a: assert property (
        resp_end && !set_evt[srv_idx_q] |=> !flag_q[$past(srv_idx_q)])
        else $error("serviced flag not cleared at vectoring");
    gie_gate_a: assert property (!gie_q |-> !irq_accept)
        else $error("interrupt taken with global enable clear");
    level_noflag_a: assert property (
        level_mode && ce |=> !flag_q[`IDL_SRC_INT0])
        else $error("level interrupt left a flag");
    push_pc_a: assert property (
        irq_accept |=> push_valid_q && push_pc_q == $past(pc_now))
        else $error("pushed value is not the program counter");
    resp_time_a: assert property (
        vector_load_q |-> age_q == (woke_q ? 4'h8 : 4'h4))
        else $error("response length wrong");
    jump_time_a: assert property (
        $fell(jump_busy) |-> age_q == (woke_q ? 4'ha : 4'h6))
        else $error("vector jump length wrong");
    boundary_a: assert property (
        irq_accept |-> instr_done || (sleeping && state_q == idl_pkg::ST_IDLE))
        else $error("interrupt taken mid-instruction");
    mask_rsvd_a: assert property (
        (external_irq_mask_reg & 8'h9f) == 8'h00 &&
        (timer_irq_mask_reg & 8'hfd) == 8'h00)
        else $error("reserved mask bits not zero");
    ret_time_a: assert property (
        ret_end |-> age_q == 4'h3 ##1 state_q == idl_pkg::ST_HOLD)
        else $error("return length wrong");
    hold_one_a: assert property (
        state_q == idl_pkg::ST_HOLD && !instr_done |-> !irq_accept)
        else $error("pending request served before one instruction");
    prio_a: assert property (
        irq_accept && req[`IDL_SRC_INT0] |=> srv_idx_q == 2'h0)
        else $error("lowest vector not preferred");

    entry_c: cover property (irq_accept && !sleeping ##[1:20] vector_load_q);
    wake_c: cover property (irq_accept && sleeping ##[1:20] vector_load_q);
    ret_c: cover property (ret_start ##[1:20] ret_end);
    nest_c: cover property (jump_busy ##[1:40] irq_accept);
endmodule

/* File: tb/idl_core_model.sv */
// Behavioural model of the core sequencer that faces the dispatch logic
`timescale 1ns/1ps
module idl_core_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic core_hold,
    input wire logic multi,
    input wire logic sleep_req,
    output logic instr_done,
    output logic sleeping,
    output logic [8:0] pc_now
);
    logic phase_q;

    // Moves on the falling edge so the dispatch logic samples stable levels
    always @(negedge core_clk or posedge rst) begin
        if (rst) begin
            instr_done <= 1'b0;
            sleeping <= 1'b0;
            pc_now <= 9'h000;
            phase_q <= 1'b0;
        end else begin
            if (instr_done) begin
                pc_now <= pc_now + 9'h001;
            end
            // A wake-up is seen as the dispatch logic taking over the core
            if (sleep_req) begin
                sleeping <= 1'b1;
            end else if (core_hold) begin
                sleeping <= 1'b0;
            end
            phase_q <= multi ? ~phase_q : 1'b0;
            instr_done <= !core_hold && !sleep_req && !sleeping
                && !(multi && !phase_q);
        end
    end
endmodule

/* File: tb/interrupt_dispatch_logic_tb_top.sv */
// Self-checking bench for the interrupt dispatch logic
`timescale 1ns/1ps
module interrupt_dispatch_logic_tb_top;
    typedef struct {logic ret; logic [8:0] vec; int gap;} idl_note_t;
    logic core_clk, rst, ce, int0_pin, pin_change_evt, timer_ovf_evt;
    logic [1:0] int0_sense;
    logic [7:0] io_wdata, rnd, ext_mask, tmr_mask, ext_flag, tmr_flag;
    logic [4:0] wr_sel;
    logic return_from_handler_instruction_exec, multi, sleep_req, instr_done, sleeping;
    logic gie_q, irq_accept, core_hold, jump_busy;
    logic push_valid_q, pop_valid_q, vector_load_q;
    logic [8:0] pc_now, push_pc_q, vector_addr_q, exp_pc;
    idl_note_t notes[$];
    int failures, checks_done, cyc, t_push, t_pop, t_vec, seed;

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    idl_dispatch uut (.core_clk(core_clk), .rst(rst), .ce(ce),
        .int0_pin(int0_pin), .int0_sense(int0_sense),
        .pin_change_evt(pin_change_evt), .timer_ovf_evt(timer_ovf_evt),
        .io_wdata(io_wdata), .ext_mask_wr(wr_sel[0]),
        .timer_mask_wr(wr_sel[1]), .ext_flag_wr(wr_sel[2]),
        .timer_flag_wr(wr_sel[3]), .gie_wr(wr_sel[4]),
        .instr_done(instr_done), .sleeping(sleeping),
        .return_from_handler_instruction_exec(return_from_handler_instruction_exec), .pc_now(pc_now), .gie_q(gie_q),
        .external_irq_mask_reg(ext_mask), .timer_irq_mask_reg(tmr_mask),
        .ext_flag_reg(ext_flag), .timer_flag_reg(tmr_flag),
        .irq_accept(irq_accept), .core_hold(core_hold),
        .jump_busy(jump_busy), .push_valid_q(push_valid_q),
        .push_pc_q(push_pc_q), .pop_valid_q(pop_valid_q),
        .vector_load_q(vector_load_q), .vector_addr_q(vector_addr_q));

    idl_core_model core (.core_clk(core_clk), .rst(rst),
        .core_hold(core_hold), .multi(multi), .sleep_req(sleep_req),
        .instr_done(instr_done), .sleeping(sleeping), .pc_now(pc_now));

    // ************************************************************
    // Checking
    // ************************************************************
    task automatic close_out();
        $display("Checks done %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic cmp(string what, logic [8:0] exp, logic [8:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_ev(idl_note_t x);
        if (x.ret) begin
            cmp("return event", 9'h001, {8'h00, pop_valid_q});
            t_pop = cyc;
        end else begin
            t_vec = cyc;
            cmp("vector", x.vec, vector_addr_q);
            cmp("response cycles", 9'(x.gap), 9'(cyc - t_push));
            cmp("serviced flag", 9'h000, {8'h00, x.vec == 9'h003 ?
                tmr_flag[1] : ext_flag[7 - x.vec]});
        end
    endtask

    // Samples 1 ns after the falling edge: inputs settled, edge not yet taken
    always @(negedge core_clk) begin
        #1;
        cyc++;
        if (cyc > 3000) begin
            failures++;
            close_out();
        end
        if (!rst && irq_accept === 1'b1) begin
            exp_pc = pc_now;
            cmp("accept at boundary", 1, instr_done | sleeping);
            cmp("accept while busy", 0, core_hold);
            cmp("accept after return", 1, cyc >= t_pop + 4);
        end
        if (!rst && push_valid_q === 1'b1) begin
            t_push = cyc;
            cmp("pushed pc", exp_pc, push_pc_q);
            cmp("gie on entry", 0, gie_q);
        end
        if (!rst && (vector_load_q === 1'b1 || pop_valid_q === 1'b1)) begin
            if (notes.size() == 0) begin
                cmp("unexpected event", 0, 1);
            end else begin
                cmp_ev(notes.pop_front());
            end
        end
        if (cyc == t_vec + 1) begin
            cmp("jump busy", 1, jump_busy);
        end
        if (cyc == t_vec + 2) begin
            cmp("jump end", 0, jump_busy | core_hold);
        end
        if (cyc == t_pop + 4) begin
            cmp("gie on return", 1, gie_q);
            cmp("return cycles", 0, core_hold);
        end
        if (!rst && int0_sense == 2'h0) begin
            cmp("level flag", 0, ext_flag[6]);
        end
    end

    // ************************************************************
    // Stimulus
    // ************************************************************
    task automatic wr(int k, logic [7:0] d);
        @(negedge core_clk);
        wr_sel = 5'h01 << k;
        io_wdata = d;
        @(negedge core_clk);
        wr_sel = 5'h00;
    endtask

    task automatic ev(logic [1:0] e);
        @(negedge core_clk);
        {timer_ovf_evt, pin_change_evt} = e;
        @(negedge core_clk);
        {timer_ovf_evt, pin_change_evt} = 2'h0;
    endtask

    task automatic note(logic r, logic [8:0] v, int g);
        notes.push_back('{r, v, g});
    endtask

    task automatic settle();
        for (int i = 0; i < 200 && (notes.size() > 0 || core_hold !== 1'b0);
                i++) begin
            @(negedge core_clk);
        end
        repeat (2) @(negedge core_clk);
    endtask

    task automatic ret();
        // The return precedes any entry already noted for after it
        notes.push_front('{1'b1, 9'h000, 0});
        @(negedge core_clk);
        return_from_handler_instruction_exec = 1'b1;
        @(negedge core_clk);
        return_from_handler_instruction_exec = 1'b0;
        settle();
    endtask

    initial begin
        seed = 59646;
        {ce, int0_pin} = 2'h3;
        {pin_change_evt, timer_ovf_evt, return_from_handler_instruction_exec, multi, sleep_req} = 5'h00;
        int0_sense = 2'h2;
        io_wdata = 8'h00;
        wr_sel = 5'h00;
        {cyc, t_push, t_vec, checks_done, failures} = 0;
        t_pop = -100;
        t_vec = -100;
        rst = 1'b1;
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        cmp("reset state", 0, {gie_q, ext_mask | tmr_mask | ext_flag | tmr_flag});
        rnd = 8'($random(seed));
        wr(0, rnd);
        cmp("ext mask", {1'b0, rnd & 8'h60}, {1'b0, ext_mask});
        wr(1, rnd);
        cmp("timer mask", {1'b0, rnd & 8'h02}, {1'b0, tmr_mask});
        wr(0, 8'h00);
        wr(1, 8'h00);
        ev(2'h3);
        cmp("flags held", 9'h022, {1'b0, ext_flag | tmr_flag});
        wr(2, rnd & 8'hdf);
        wr(3, rnd & 8'hfd);
        cmp("zero keeps", 9'h022, {1'b0, ext_flag | tmr_flag});
        wr(2, 8'h20);
        cmp("one clears", 9'h000, {1'b0, ext_flag});
        ev(2'h1);
        wr(0, 8'h60);
        wr(1, 8'h02);
        repeat (5) @(negedge core_clk);
        cmp("waits for gie", 9'h022, {1'b0, ext_flag | tmr_flag});
        note(1'b0, 9'h002, 4);
        wr(4, 8'h80);
        settle();
        note(1'b0, 9'h003, 4);
        ret();
        ev(2'h1);
        note(1'b0, 9'h002, 4);
        wr(4, 8'h80);
        settle();
        ret();
        ret();
        wr(0, 8'h00);
        for (int s = 1; s < 4; s++) begin
            int0_sense = 2'(s);
            @(negedge core_clk);
            int0_pin = 1'b0;
            repeat (2) @(negedge core_clk);
            cmp("fall flag", 9'(s != 3), {8'h00, ext_flag[6]});
            wr(2, 8'h40);
            int0_pin = 1'b1;
            repeat (2) @(negedge core_clk);
            cmp("rise flag", 9'(s != 2), {8'h00, ext_flag[6]});
            wr(2, 8'h40);
        end
        int0_sense = 2'h0;
        wr(0, 8'h40);
        note(1'b0, 9'h001, 4);
        int0_pin = 1'b0;
        settle();
        int0_pin = 1'b1;
        ret();
        // The core model samples on this same edge, so drive it late
        sleep_req <= 1'b1;
        @(negedge core_clk);
        sleep_req <= 1'b0;
        repeat (2) @(negedge core_clk);
        note(1'b0, 9'h003, 8);
        ev(2'h2);
        settle();
        ret();
        multi <= 1'b1;
        note(1'b0, 9'h003, 4);
        ev(2'h2);
        settle();
        ret();
        multi <= 1'b0;
        cmp("notes left", 0, 9'(notes.size()));
        close_out();
    end
endmodule
